// ==== core/embf_pkg.sv ====
package embf_pkg;
	// ======================================================
	// Transfer block layout (word indices)
	localparam int BLOCK_WORDS = 250;
	localparam logic [7:0] WI_RESERVED = 8'h00;
	localparam logic [7:0] WI_NEXT_ID = 8'h01;
	localparam logic [7:0] WI_COUNT = 8'h02;
	localparam logic [7:0] WI_FIRST_REC = 8'h03;
	localparam logic [7:0] WI_FIRST_SPARE = 8'hcb;
	localparam logic [7:0] WI_BLOCK_ID = 8'hf9;
	localparam logic [15:0] EV_BLOCK_ID = 16'h26af;
	localparam int REC_WORDS = 10;
	localparam logic [4:0] MAX_RECS = 5'h14;
	localparam int OVF_LIMIT = 200;

	// ======================================================
	// Event message fields
	localparam logic [7:0] COT_SPONT = 8'h01;
	localparam logic [7:0] ASDU_T1 = 8'h01;
	localparam logic [7:0] ASDU_T2 = 8'h02;
	localparam logic [7:0] ASDU_T4 = 8'h04;
	localparam int BIT_TIME_INV = 0;
	localparam int BIT_DST = 1;

	// ======================================================
	// Register map (byte addresses) and fields
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_NEXT_ID = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam int BIT_PASS_EN = 0;
	localparam int BIT_OVF = 16;
	localparam int BIT_BUSY = 17;
	localparam logic RST_PASS_EN = 1'b0;
	localparam logic [15:0] RST_NEXT_ID = 16'h0000;

	// ======================================================
	// Carriers
	typedef struct packed {
		logic valid;
		logic [7:0] sessionIdx;
		logic [7:0] sectorIdx;
		logic [7:0] asduType;
		logic [7:0] funcCode;
		logic [7:0] pointIdx;
		logic [7:0] cause;
		logic [15:0] faultNum;
		logic [15:0] msec;
		logic [7:0] hour;
		logic [7:0] minute;
		logic timeInvalid;
		logic dst;
		logic [15:0] relTime;
		logic [31:0] value;
	} embf_ev_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] index;
		logic [15:0] data;
	} embf_blk_t;

	typedef logic [REC_WORDS-1:0][15:0] embf_rec_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_RETIRE = 2'b11
	} embf_state_t;
endpackage

// ==== core/embf_event_framer.sv ====
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module embf_event_framer #(
	parameter int DEPTH = 256,
	parameter int ADDR_W = 12
) (
	input wire logic clk, // 100 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire embf_pkg::embf_ev_t evIn, // Station message from the master port
	input wire logic outReady, // Processor takes the current word
	output embf_pkg::embf_blk_t blkOut, // Event block word stream
	output logic ordGrant, // Ordinary blocks may go out
	output logic evOverflow // Overflow flag for the status area
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W:0] OVF_C = (PTR_W+1)'(embf_pkg::OVF_LIMIT);
	localparam logic [3:0] LAST_REC_WORD = 4'(embf_pkg::REC_WORDS - 1);
	localparam logic [7:0] LAST_INDEX = 8'(embf_pkg::BLOCK_WORDS - 1);

	typedef struct packed {
		embf_pkg::embf_state_t state;
		logic passEn;
		logic [15:0] nextId;
		logic overflow;
		logic [PTR_W-1:0] wrPtr;
		logic [PTR_W-1:0] rdPtr;
		logic [PTR_W:0] count;
		logic [4:0] blkCnt;
		logic [4:0] recIdx;
		logic [3:0] recWord;
		embf_pkg::embf_blk_t out;
		logic ordGrant;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} embf_core_t;

	embf_core_t s;
	embf_core_t next_s;
	embf_pkg::embf_rec_t evBuf [DEPTH];
	embf_pkg::embf_rec_t curRec;
	logic capture;
	logic apbWrite;
	logic [PTR_W:0] retireN;

	// ======================================================
	// Record builder
	function automatic embf_pkg::embf_rec_t buildRec(input embf_pkg::embf_ev_t e);
		embf_pkg::embf_rec_t r;
		logic faultType;
		logic [31:0] val;
		r = '0;
		faultType = (e.asduType == embf_pkg::ASDU_T2) || (e.asduType == embf_pkg::ASDU_T4);
		r[0] = {e.sessionIdx, e.sectorIdx};
		r[1] = {8'h00, e.asduType};
		r[2] = {e.funcCode, e.pointIdx};
		// Fields that carry no meaning for other types are zeroed, not left stale
		r[3] = faultType ? e.faultNum : 16'h0000;
		r[4] = e.msec;
		r[5] = {e.hour, e.minute};
		r[6][embf_pkg::BIT_TIME_INV] = e.timeInvalid;
		r[6][embf_pkg::BIT_DST] = e.dst;
		r[7] = faultType ? e.relTime : 16'h0000;
		val = e.value;
		if ((e.asduType == embf_pkg::ASDU_T1) || (e.asduType == embf_pkg::ASDU_T2)) begin
			val = {30'h0, e.value[1:0]};
		end
		r[8] = val[15:0];
		r[9] = val[31:16];
		return r;
	endfunction

	function automatic logic [4:0] blockCount(input logic [PTR_W:0] cnt);
		if (cnt >= (PTR_W+1)'(embf_pkg::MAX_RECS)) begin
			return embf_pkg::MAX_RECS;
		end
		return cnt[4:0];
	endfunction

	assign curRec = evBuf[s.rdPtr + PTR_W'(s.recIdx)];

	// ======================================================
	// Next-state logic
	always_comb begin
		next_s = s;
		capture = 1'b0;
		retireN = '0;
		apbWrite = psel && penable && s.pready && pwrite;

		// One wait state: read data and error are registered at the same edge as pready
		next_s.pready = psel && penable && !s.pready;
		// Answer fields fall back to zero so a stale error never outlives its cycle
		next_s.pslverr = 1'b0;
		next_s.prdata = 32'h0000_0000;
		if (psel && penable && !s.pready) begin
			case (paddr)
				embf_pkg::REG_CTRL: begin
					next_s.prdata[embf_pkg::BIT_PASS_EN] = s.passEn;
				end
				embf_pkg::REG_NEXT_ID: begin
					next_s.prdata[15:0] = s.nextId;
				end
				embf_pkg::REG_STATUS: begin
					next_s.prdata = 32'(s.count);
					next_s.prdata[embf_pkg::BIT_OVF] = s.overflow;
					next_s.prdata[embf_pkg::BIT_BUSY] = (s.state != embf_pkg::ST_IDLE);
				end
				default: begin
					next_s.pslverr = 1'b1;
				end
			endcase
		end
		if (apbWrite && !s.pslverr) begin
			if (paddr == embf_pkg::REG_CTRL) begin
				next_s.passEn = pwdata[embf_pkg::BIT_PASS_EN];
			end
			if (paddr == embf_pkg::REG_NEXT_ID) begin
				next_s.nextId = pwdata[15:0];
			end
		end

		// A full buffer drops the event; the overflow flag is already up then
		capture = evIn.valid && s.passEn && (evIn.cause == embf_pkg::COT_SPONT)
			&& (s.count != DEPTH_C);
		if (capture) begin
			next_s.wrPtr = s.wrPtr + PTR_W'(1);
		end

		case (s.state)
			embf_pkg::ST_IDLE: begin
				if (s.passEn && (s.count != '0)) begin
					next_s.state = embf_pkg::ST_SEND;
					next_s.blkCnt = blockCount(s.count);
					next_s.recIdx = 5'h00;
					next_s.recWord = 4'h0;
					next_s.out.valid = 1'b1;
					next_s.out.last = 1'b0;
					next_s.out.index = embf_pkg::WI_RESERVED;
					next_s.out.data = 16'h0000;
				end
			end
			embf_pkg::ST_SEND: begin
				if (s.out.valid && outReady) begin
					if (s.out.last) begin
						next_s.out.valid = 1'b0;
						next_s.state = embf_pkg::ST_RETIRE;
					end else begin
						next_s.out.index = s.out.index + 8'h01;
						next_s.out.last = (next_s.out.index == LAST_INDEX);
						next_s.out.data = 16'h0000;
						if (next_s.out.index == embf_pkg::WI_NEXT_ID) begin
							next_s.out.data = s.nextId;
						end else if (next_s.out.index == embf_pkg::WI_COUNT) begin
							next_s.out.data = {11'h000, s.blkCnt};
						end else if (next_s.out.index == embf_pkg::WI_BLOCK_ID) begin
							next_s.out.data = embf_pkg::EV_BLOCK_ID;
						end else if ((next_s.out.index >= embf_pkg::WI_FIRST_REC)
							&& (s.recIdx < s.blkCnt)) begin
							next_s.out.data = curRec[s.recWord];
							if (s.recWord == LAST_REC_WORD) begin
								next_s.recWord = 4'h0;
								next_s.recIdx = s.recIdx + 5'h01;
							end else begin
								next_s.recWord = s.recWord + 4'h1;
							end
						end
					end
				end
			end
			embf_pkg::ST_RETIRE: begin
				// Nothing comes back from the processor, so retire at once
				retireN = (PTR_W+1)'(s.blkCnt);
				next_s.rdPtr = s.rdPtr + PTR_W'(s.blkCnt);
				next_s.state = embf_pkg::ST_IDLE;
			end
			default: begin
				next_s.state = embf_pkg::ST_IDLE;
				next_s.out.valid = 1'b0;
			end
		endcase

		next_s.count = s.count + (PTR_W+1)'(capture) - retireN;

		// Software clears by writing one; a new overflow in that cycle wins
		if (apbWrite && (paddr == embf_pkg::REG_STATUS) && pwdata[embf_pkg::BIT_OVF]) begin
			next_s.overflow = 1'b0;
		end
		if (next_s.count > OVF_C) begin
			next_s.overflow = 1'b1;
		end

		next_s.ordGrant = (next_s.state == embf_pkg::ST_IDLE) && (next_s.count == '0);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.state <= embf_pkg::ST_IDLE;
			s.passEn <= embf_pkg::RST_PASS_EN;
			s.nextId <= embf_pkg::RST_NEXT_ID;
			s.ordGrant <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Buffer storage needs no reset: pointers decide what is valid
	always_ff @(posedge clk) begin
		if (capture) begin
			evBuf[s.wrPtr] <= buildRec(evIn);
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign blkOut = s.out;
	assign ordGrant = s.ordGrant;
	assign evOverflow = s.overflow;

	// ======================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	lastWordId_a: assert property (s.out.valid && s.out.last
		|-> s.out.data == embf_pkg::EV_BLOCK_ID && s.out.index == embf_pkg::WI_BLOCK_ID)
		else $error("last block word is not the event block id");
	nextIdWord_a: assert property (s.out.valid && s.out.index == embf_pkg::WI_NEXT_ID
		|-> s.out.data == s.nextId)
		else $error("word 1 does not carry the next block id");
	countWord_a: assert property (s.out.valid && s.out.index == embf_pkg::WI_COUNT
		|-> s.out.data >= 16'h0001 && s.out.data <= 16'(embf_pkg::MAX_RECS))
		else $error("event count word out of range");
	recordStart_a: assert property (s.out.valid && s.out.index == embf_pkg::WI_FIRST_REC
		|-> s.recIdx == 5'h00 && s.recWord == 4'h1)
		else $error("first record does not start at word 3");
	spontOnly_a: assert property (capture
		|-> evIn.cause == embf_pkg::COT_SPONT && s.passEn)
		else $error("event captured without spontaneous cause or enable");
	recordBuilt_a: assert property (capture && s.state != embf_pkg::ST_RETIRE
		|=> s.count == $past(s.count) + 1'b1)
		else $error("captured event not added to the buffer");
	ordBlocked_a: assert property (s.count != '0 || s.state != embf_pkg::ST_IDLE
		|-> !s.ordGrant)
		else $error("ordinary block granted while events are pending");
	eventsRetired_a: assert property (s.state == embf_pkg::ST_RETIRE && !capture
		|=> s.count == $past(s.count) - $past(s.blkCnt))
		else $error("sent events not removed from the buffer");
	overflowSet_a: assert property (s.count > OVF_C |=> s.overflow)
		else $error("overflow flag not set above the limit");
	noResponse_a: assert property (s.state == embf_pkg::ST_RETIRE
		|=> s.state == embf_pkg::ST_IDLE)
		else $error("framer waits after sending a block");
	spareZero_a: assert property (s.out.valid && (s.out.index == embf_pkg::WI_RESERVED
		|| (s.out.index >= embf_pkg::WI_FIRST_SPARE && s.out.index < embf_pkg::WI_BLOCK_ID))
		|-> s.out.data == 16'h0000)
		else $error("reserved or spare word not zero");
	holdWord_a: assert property (s.out.valid && !outReady
		|=> s.out.valid && $stable(s.out.data) && $stable(s.out.index))
		else $error("block word changed while stalled");

	// ======================================================
	// Register bus checks
	// One wait state, and pslverr and prdata drop back to zero after the answer
	readyPulse_a: assert property (pready |=> !pready)
		else $error("pready held for more than one cycle");
	readyWait_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	answerInside_a: assert property (pready |-> psel && penable)
		else $error("pready raised outside an access");
	errorWithReady_a: assert property (pslverr |-> pready)
		else $error("pslverr raised without pready");
	errorDataZero_a: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returned data");
	passWrite_a: assert property (apbWrite && paddr == embf_pkg::REG_CTRL
		&& pwdata[embf_pkg::BIT_PASS_EN] |=> s.passEn)
		else $error("pass-through enable write lost");
	nextIdWrite_a: assert property (apbWrite && paddr == embf_pkg::REG_NEXT_ID
		|=> s.nextId == 16'($past(pwdata)))
		else $error("next block id write lost");

	// ======================================================
	// Buffer and stream checks
	// A full buffer drops, so the count never passes the depth
	countBound_a: assert property (s.count <= DEPTH_C)
		else $error("event count above buffer depth");
	fullDrop_a: assert property (s.count == DEPTH_C |-> !capture)
		else $error("event captured into a full buffer");
	overflowSticky_a: assert property (s.overflow && !(apbWrite
		&& paddr == embf_pkg::REG_STATUS && pwdata[embf_pkg::BIT_OVF]) |=> s.overflow)
		else $error("overflow flag dropped without a clear");
	ordGrantMatch_a: assert property (s.ordGrant
		== (s.state == embf_pkg::ST_IDLE && s.count == '0))
		else $error("ordinary grant disagrees with pending events");
	startWord_a: assert property (s.state == embf_pkg::ST_IDLE && s.passEn
		&& s.count != '0 |=> s.out.valid && s.out.index == embf_pkg::WI_RESERVED)
		else $error("pending events did not start a block");
	noStartOff_a: assert property (s.state == embf_pkg::ST_IDLE && !s.passEn
		|=> s.state == embf_pkg::ST_IDLE)
		else $error("block started while pass-through is off");
	idleQuiet_a: assert property (s.state != embf_pkg::ST_SEND |-> !s.out.valid)
		else $error("block word valid outside sending");
	wordAdvance_a: assert property (s.out.valid && outReady && !s.out.last
		|=> s.out.valid && s.out.index == $past(s.out.index) + 8'h01)
		else $error("block word index did not advance by one");
	lastDrop_a: assert property (s.out.valid && s.out.last && outReady
		|=> !s.out.valid && s.state == embf_pkg::ST_RETIRE)
		else $error("stream not closed after the last word");
	lastIndex_a: assert property (s.out.valid
		&& s.out.index == embf_pkg::WI_BLOCK_ID |-> s.out.last)
		else $error("last flag missing on the final word");
	blkCntRange_a: assert property (s.state == embf_pkg::ST_SEND
		|-> s.blkCnt != 5'h00 && s.blkCnt <= embf_pkg::MAX_RECS)
		else $error("block record count out of range");
	retireBound_a: assert property (s.state != embf_pkg::ST_IDLE
		|-> (PTR_W+1)'(s.blkCnt) <= s.count)
		else $error("block carries more events than buffered");
	// Record word 1 leaves as recWord reaches 2, record word 6 as it reaches 7
	asduHigh_a: assert property (s.out.valid && s.out.index >= embf_pkg::WI_FIRST_REC
		&& s.out.index < embf_pkg::WI_FIRST_SPARE && s.recWord == 4'h2
		|-> s.out.data[15:8] == 8'h00)
		else $error("type word upper byte not zero");
	flagBits_a: assert property (s.out.valid && s.out.index >= embf_pkg::WI_FIRST_REC
		&& s.out.index < embf_pkg::WI_FIRST_SPARE && s.recWord == 4'h7
		|-> s.out.data[15:2] == 14'h0000)
		else $error("time flag word has stray bits");

	// ======================================================
	// Main scenarios
	blockSent_c: cover property (s.out.valid && s.out.last && outReady);
	stallResume_c: cover property (s.out.valid && !outReady ##1 s.out.valid && outReady);
	fullBlock_c: cover property (s.state == embf_pkg::ST_SEND && s.blkCnt == 5'h14);
	overflow_c: cover property (!s.overflow ##1 s.overflow);
	backToBack_c: cover property (s.state == embf_pkg::ST_RETIRE ##2 s.state == embf_pkg::ST_SEND);
endmodule

// ==== verification/embf_host_model.sv ====
`timescale 1ns/1ps
// ==================================================
// Processor side: takes block words, never answers
module embf_host_model (
	input wire logic clk, // 100 MHz
	input wire logic rst_b, // Async reset, active low
	input wire embf_pkg::embf_blk_t blk, // Event block word stream
	input wire logic hold, // Stall every word
	input wire logic slow, // Take a word every other cycle
	output logic outReady, // Word taken at this edge
	output int blocks // Blocks received so far
);
	logic [15:0] mem [0:249];
	logic [15:0] cnts [0:15];
	logic tick;

	// Pacing is our own; no response block is ever returned
	assign outReady = !hold && (!slow || tick);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick <= 1'b0;
			blocks <= 0;
		end else begin
			tick <= !tick;
			if (blk.valid && outReady) begin
				mem[blk.index] <= blk.data;
				if (blk.index == 8'h02) begin
					cnts[blocks[3:0]] <= blk.data;
				end
				if (blk.last) begin
					blocks <= blocks + 1;
				end
			end
		end
	end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0, slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, err, outReady, ordGrant, evOverflow;
	embf_pkg::embf_ev_t evIn = '0;
	embf_pkg::embf_blk_t blkOut;
	int blocks, errors = 0, checked = 0, cycles = 0;
	logic [7:0] types [3] = '{8'h01, 8'h02, 8'h04};

	always #5 clk = ~clk;

	embf_event_framer embf_event_framer_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .evIn, .outReady, .blkOut, .ordGrant,
		.evOverflow);
	embf_host_model embf_host_model_i (.clk, .rst_b, .blk(blkOut), .hold, .slow,
		.outReady, .blocks);

	// ==================================================
	// Tasks
	task conclude();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task ev(input logic [7:0] c, input logic [7:0] t, input int n);
		@(posedge clk);
		evIn <= '{1'b1, 8'h5a, 8'h3c, t, 8'h9e, 8'h21, c, 16'h0bad, 16'hea5f, 8'h17,
			8'h3b, 1'b1, t[1], 16'h1357, 32'hc0ffee03};
		repeat (n) @(posedge clk);
		evIn.valid <= 1'b0;
	endtask

	function automatic logic [15:0] recw(input logic [7:0] t, input int k);
		logic ft;
		ft = (t != 8'h01);
		case (k)
			0: return 16'h5a3c;
			1: return {8'h00, t};
			2: return 16'h9e21;
			3: return ft ? 16'h0bad : 16'h0000;
			4: return 16'hea5f;
			5: return 16'h173b;
			6: return {14'h0000, t[1], 1'b1};
			7: return ft ? 16'h1357 : 16'h0000;
			8: return (t == 8'h04) ? 16'hee03 : 16'h0003;
			default: return (t == 8'h04) ? 16'hc0ff : 16'h0000;
		endcase
	endfunction

	// ==================================================
	// Watchdog: the whole run needs well under this
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
	end

	// ==================================================
	// Sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, embf_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, embf_pkg::REG_NEXT_ID, 32'h0);
		chk("next id reg", 32'h0, rd);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, embf_pkg::REG_NEXT_ID, 32'h00001234);
		apb(1'b1, embf_pkg::REG_CTRL, 32'h00000001);
		foreach (types[i]) begin
			ev(8'h01, types[i], 1);
			while (blocks != i + 1) @(posedge clk);
			chk("reserved", 32'h0, embf_host_model_i.mem[0]);
			chk("next id", 32'h1234, embf_host_model_i.mem[1]);
			chk("count", 32'h1, embf_host_model_i.mem[2]);
			for (int k = 0; k < 10; k++) begin
				chk("record", recw(types[i], k), embf_host_model_i.mem[3 + k]);
			end
			chk("spare", 32'h0, embf_host_model_i.mem[13]);
			chk("spare end", 32'h0, embf_host_model_i.mem[248]);
			chk("block id", embf_pkg::EV_BLOCK_ID, embf_host_model_i.mem[249]);
		end
		ev(8'h03, 8'h01, 1);
		repeat (4) @(posedge clk);
		apb(1'b0, embf_pkg::REG_STATUS, 32'h0);
		chk("status idle", 32'h0, rd);
		chk("grant idle", 32'h1, ordGrant);
		chk("blocks", 32'd3, blocks);
		// Stall the processor so the buffer fills past the overflow mark
		hold <= 1'b1;
		ev(8'h01, 8'h01, 1);
		repeat (4) @(posedge clk);
		ev(8'h01, 8'h02, 201);
		repeat (2) @(posedge clk);
		apb(1'b0, embf_pkg::REG_STATUS, 32'h0);
		chk("status full", 32'h000300ca, rd);
		chk("overflow", 32'h1, evOverflow);
		chk("grant busy", 32'h0, ordGrant);
		slow <= 1'b1;
		hold <= 1'b0;
		while (blocks != 15) @(posedge clk);
		repeat (3) @(posedge clk);
		chk("first count", 32'h1, embf_host_model_i.cnts[3]);
		chk("full count", 32'd20, embf_host_model_i.cnts[4]);
		chk("tail count", 32'h1, embf_host_model_i.cnts[14]);
		apb(1'b0, embf_pkg::REG_STATUS, 32'h0);
		chk("status drained", 32'h00010000, rd);
		apb(1'b1, embf_pkg::REG_STATUS, 32'h00010000);
		apb(1'b0, embf_pkg::REG_STATUS, 32'h0);
		chk("status cleared", 32'h0, rd);
		chk("overflow clear", 32'h0, evOverflow);
		apb(1'b1, embf_pkg::REG_CTRL, 32'h0);
		ev(8'h01, 8'h04, 1);
		repeat (4) @(posedge clk);
		apb(1'b0, embf_pkg::REG_STATUS, 32'h0);
		chk("pass off", 32'h0, rd);
		chk("blocks end", 32'd15, blocks);
		conclude();
	end
endmodule
